// *** aca_map.vh ***
/*
 * register map, field positions, reset values and sizes of the ambient
 * calibration block.
 * assumes a 32-bit AXI4-Lite slave whose byte address is four times
 * the register index; 8 address bits are decoded.
 */
`ifndef ACA_MAP_VH
`define ACA_MAP_VH

// ****************************************
// register indices and byte addresses
// ****************************************
`define ACA_IDX_SKIP 6'h01
`define ACA_IDX_FFSKIP 6'h02
`define ACA_IDX_UPDATE 6'h03
`define ACA_IDX_CFG 6'h08
`define ACA_IDX_SEL 6'h09
`define ACA_IDX_OFFH 6'h0A
`define ACA_IDX_OFFL 6'h0B
`define ACA_IDX_SENS 6'h0C
`define ACA_IDX_AMB 6'h0D
`define ACA_IDX_THRH 6'h0E
`define ACA_IDX_THRL 6'h0F
`define ACA_IDX_AVGMAX 6'h10
`define ACA_IDX_AVGMIN 6'h11
`define ACA_IDX_TOUCH 6'h12
`define ACA_ADDR(i) ({(i), 2'b00})

// ****************************************
// field positions
// ****************************************
`define ACA_FP_SKIP_LSB 12
`define ACA_LP_SKIP_LSB 14
`define ACA_PUSH_LVL_LSB 0
`define ACA_CFG_LP_BIT 8

// ****************************************
// reset values and sizes
// ****************************************
`define ACA_SKIP_RST 16'h0000
`define ACA_UPDATE_RST 16'h0000
`define ACA_CFG_RST 16'h000B
`define ACA_STAGES 12
`define ACA_SF_DEPTH 4
`define ACA_RESP_OK 2'h0
`define ACA_RESP_ERR 2'h2

`endif

// *** aca_thresh.v ***
/*
 * one threshold from ambient, offset and a 4-bit sensitivity select.
 * assumes a purely combinational use inside the calibration core.
 */
`timescale 1ns/1ps
`default_nettype none

module aca_thresh
(
	input wire [15:0] ambient,
	input wire [15:0] offset,
	input wire [3:0] sens,
	input wire below,
	output reg [15:0] thr
);

	// ****************************************
	// threshold arithmetic
	// ****************************************
	reg [17:0] quarter; // a quarter of the offset
	reg [23:0] prod; // quarter times sensitivity weight
	reg [17:0] scaled; // weight in 64ths: 16 + 3*sel, 25% .. 95.3%
	reg [17:0] sum; // ambient +/- both terms

	// level 8 gives 40/64, about 62.5% of the quarter offset
	always @*
	begin
		quarter = {4'h0, offset[15:2]};
		prod = quarter[15:0] * ({4'h0, sens} * 8'h03 + 8'h10);
		scaled = {2'h0, prod[21:6]};
		if (below)
		begin
			// lower threshold falls under ambient
			sum = {2'h0, ambient} - quarter - scaled;
			thr = sum[17] ? 16'h0000 : sum[15:0];
		end
		else
		begin
			sum = {2'h0, ambient} + quarter + scaled;
			thr = sum[16] ? 16'hFFFF : sum[15:0];
		end
	end

endmodule // aca_thresh

`default_nettype wire

// *** aca_top.v ***
/*
 * ambient calibration and adaptive threshold core with AXI4-Lite slave.
 * assumes converter results arrive on the aclk domain, one per cycle at
 * most, tagged with their stage number.
 */
// Decided for this implementation: register access over AXI4-Lite.
// Behaviour
// - offsets follow measured ambient drift per sensor
// - offset change recomputes both thresholds automatically
// - one slow fifo per sensor in memory
// - full/low power skip in bits 13:12, 15:14
// - skip settings drop samples from slow fifo
// - full power period scales with full-power skip
// - low power period scales with skip plus one
// - push only when change exceeds update level
// - threshold is ambient plus scaled quarter offsets
// - thresholds relative to ambient; contact exceeds them
// - track running average maximum and minimum responses
// - average change rescales that sensor's thresholds
// - sixteen sensitivity levels, 25% to 95.32%
// - positive select 1000 gives about 62.5%
// - lower select puts threshold nearer ambient
// - compensation runs only while sensor untouched
// - active-low interrupt when threshold is passed
// - averages update only inside peak windows
`timescale 1ns/1ps
`default_nettype none
`include "aca_map.vh"

module aca_top
(
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire conv_valid,
	input wire [3:0] conv_stage,
	input wire [15:0] conv_data,
	output reg int_n
);

	// ****************************************
	// functions
	// ****************************************
	// byte-lane merge of a 16-bit register
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] st;
		begin
			merge16 = {st[1] ? wd[15:8] : old[15:8],
				st[0] ? wd[7:0] : old[7:0]};
		end
	endfunction

	// distance between two samples
	function [15:0] absdiff;
		input [15:0] a;
		input [15:0] b;
		begin
			absdiff = (a > b) ? a - b : b - a;
		end
	endfunction

	// clamp an 18-bit signed value into 0..FFFF
	function [15:0] sat16;
		input [17:0] v;
		begin
			if (v[17])
				sat16 = 16'h0000;
			else if (v[16])
				sat16 = 16'hFFFF;
			else
				sat16 = v[15:0];
		end
	endfunction

	// ****************************************
	// registers and per-stage memory
	// ****************************************
	reg [15:0] skip_ctrl; // ambient_skip_control
	reg [15:0] update_ctrl; // ambient_update_control
	reg [3:0] fast_fifo_skip_count;
	reg [15:0] cfg; // last stage of a sequence and power mode
	reg [3:0] sel; // stage seen through the window regs
	reg [15:0] sf_mem [0:47]; // slow fifos, four words per stage
	reg [1:0] sf_ptr [0:11]; // slow fifo write pointers
	reg [15:0] ambient_level_value [0:11];
	reg [15:0] last_push [0:11]; // last word pushed per stage
	reg [15:0] off_h [0:11]; // upper offset
	reg [15:0] off_l [0:11]; // lower offset
	reg [15:0] sens [0:11]; // pos, neg, pos window, neg window
	reg [15:0] avg_max [0:11];
	reg [15:0] avg_min [0:11];
	reg [15:0] thr_h [0:11];
	reg [15:0] thr_l [0:11];
	reg [11:0] seeded; // stage has seen its first sample
	reg [11:0] touch_h; // result above upper threshold
	reg [11:0] touch_l; // result below lower threshold
	reg [7:0] skip_cnt; // sequences since last push window
	reg rc_valid; // threshold recompute pending
	reg [3:0] rc_stage; // stage to recompute
	integer i;

	wire [1:0] slow_fifo_skip_full_power = skip_ctrl[`ACA_FP_SKIP_LSB+1:`ACA_FP_SKIP_LSB];
	wire [1:0] slow_fifo_skip_low_power = skip_ctrl[`ACA_LP_SKIP_LSB+1:`ACA_LP_SKIP_LSB];
	wire [7:0] ambient_push_level = update_ctrl[`ACA_PUSH_LVL_LSB+7:`ACA_PUSH_LVL_LSB];
	wire low_power = cfg[`ACA_CFG_LP_BIT];

	// ****************************************
	// skip window length in whole sequences
	// ****************************************
	reg [7:0] skip_limit;

	// full power: skip x (fast skip + 1); low power: skip + 1
	always @*
	begin
		if (low_power)
			skip_limit = {6'h00, slow_fifo_skip_low_power} + 8'h01;
		else
			skip_limit = {6'h00, slow_fifo_skip_full_power}
				* ({4'h0, fast_fifo_skip_count} + 8'h01);
		if (skip_limit == 8'h00)
			skip_limit = 8'h01;
	end

	// ****************************************
	// current result decode
	// ****************************************
	wire [3:0] s = conv_stage;
	wire hit = conv_valid && (conv_stage < `ACA_STAGES);
	wire [15:0] amb_s = ambient_level_value[s];
	wire above = conv_data > thr_h[s];
	wire beneath = conv_data < thr_l[s];
	wire [5:0] base = {s, 2'b00};
	wire [17:0] sf_sum = {2'h0, sf_mem[base]} + {2'h0, sf_mem[base + 6'd1]}
		+ {2'h0, sf_mem[base + 6'd2]} + {2'h0, sf_mem[base + 6'd3]}
		- {2'h0, sf_mem[base + {4'h0, sf_ptr[s]}]} + {2'h0, conv_data};
	wire [15:0] new_amb = sf_sum[17:2]; // mean of the four entries
	wire [17:0] drift = {2'h0, new_amb} - {2'h0, amb_s};
	wire [17:0] half_drift = {drift[17], drift[17:1]};
	wire push_now = (skip_cnt == 8'h00)
		&& (absdiff(conv_data, last_push[s]) > {8'h00, ambient_push_level});

	// peak windows as fractions (in 16ths) of the reach from ambient
	wire [15:0] reach_max = avg_max[s] - amb_s;
	wire [15:0] reach_min = amb_s - avg_min[s];
	wire [19:0] win_max = reach_max * sens[s][11:8];
	wire [19:0] win_min = reach_min * sens[s][15:12];
	wire max_in = (conv_data > amb_s)
		&& ({2'h0, conv_data} + {2'h0, win_max[19:4]} >= {2'h0, avg_max[s]});
	wire min_in = (conv_data < amb_s)
		&& ({2'h0, conv_data} <= {2'h0, avg_min[s]} + {2'h0, win_min[19:4]});
	wire [17:0] nxt_max = {2'h0, avg_max[s]}
		+ {4'h0, conv_data[15:2]} - {4'h0, avg_max[s][15:2]};
	wire [17:0] nxt_min = {2'h0, avg_min[s]}
		+ {4'h0, conv_data[15:2]} - {4'h0, avg_min[s][15:2]};

	// ****************************************
	// threshold calculators on the recompute stage
	// ****************************************
	wire [15:0] calc_h;
	wire [15:0] calc_l;

	aca_thresh u_thr_h
	(
		.ambient(ambient_level_value[rc_stage]),
		.offset(off_h[rc_stage]),
		.sens(sens[rc_stage][3:0]),
		.below(1'b0),
		.thr(calc_h)
	);

	aca_thresh u_thr_l
	(
		.ambient(ambient_level_value[rc_stage]),
		.offset(off_l[rc_stage]),
		.sens(sens[rc_stage][7:4]),
		.below(1'b1),
		.thr(calc_l)
	);

	// ****************************************
	// bus decode
	// ****************************************
	wire wr_take = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	wire [7:0] wa = s_axi_awaddr;
	wire wr_map = (wa == `ACA_ADDR(`ACA_IDX_SKIP)) || (wa == `ACA_ADDR(`ACA_IDX_FFSKIP))
		|| (wa == `ACA_ADDR(`ACA_IDX_UPDATE)) || (wa == `ACA_ADDR(`ACA_IDX_CFG))
		|| (wa == `ACA_ADDR(`ACA_IDX_SEL)) || (wa == `ACA_ADDR(`ACA_IDX_OFFH))
		|| (wa == `ACA_ADDR(`ACA_IDX_OFFL)) || (wa == `ACA_ADDR(`ACA_IDX_SENS));

	// ****************************************
	// calibration engine and register writes
	// ****************************************
	// one process owns every per-stage array so the host write can
	// simply land after the engine and win in the same edge
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			skip_ctrl <= `ACA_SKIP_RST;
			update_ctrl <= `ACA_UPDATE_RST;
			fast_fifo_skip_count <= 4'h0;
			cfg <= `ACA_CFG_RST;
			sel <= 4'h0;
			seeded <= 12'h000;
			touch_h <= 12'h000;
			touch_l <= 12'h000;
			skip_cnt <= 8'h00;
			rc_valid <= 1'b0;
			rc_stage <= 4'h0;
			int_n <= 1'b1;
			for (i = 0; i < 48; i = i + 1)
				sf_mem[i] <= 16'h0000;
			for (i = 0; i < 12; i = i + 1)
			begin
				sf_ptr[i] <= 2'h0;
				ambient_level_value[i] <= 16'h0000;
				last_push[i] <= 16'h0000;
				off_h[i] <= 16'h0000;
				off_l[i] <= 16'h0000;
				sens[i] <= 16'h0000;
				avg_max[i] <= 16'h0000;
				avg_min[i] <= 16'h0000;
				thr_h[i] <= 16'hFFFF;
				thr_l[i] <= 16'h0000;
			end
		end
		else
		begin
			rc_valid <= 1'b0;
			// store freshly computed thresholds
			if (rc_valid)
			begin
				thr_h[rc_stage] <= calc_h;
				thr_l[rc_stage] <= calc_l;
			end
			// contact flags drive the interrupt pin
			int_n <= ~(|touch_h || |touch_l);
			if (hit)
			begin
				// no ambient yet before the seed, so no contact either
				touch_h[s] <= above && seeded[s];
				touch_l[s] <= beneath && seeded[s];
				rc_valid <= 1'b1;
				rc_stage <= s;
				// sequence boundary advances the skip window
				if (s == cfg[3:0])
					skip_cnt <= (skip_cnt + 8'h01 >= skip_limit) ?
						8'h00 : skip_cnt + 8'h01;
				if (!seeded[s])
				begin
					// first sample fills the fifo flat
					seeded[s] <= 1'b1;
					sf_mem[base] <= conv_data;
					sf_mem[base + 6'd1] <= conv_data;
					sf_mem[base + 6'd2] <= conv_data;
					sf_mem[base + 6'd3] <= conv_data;
					ambient_level_value[s] <= conv_data;
					last_push[s] <= conv_data;
					avg_max[s] <= sat16({2'h0, conv_data} + {2'h0, off_h[s]});
					avg_min[s] <= sat16({2'h0, conv_data} - {2'h0, off_l[s]});
				end
				else if (!above && !beneath)
				begin
					// untouched: ambient tracking only
					if (push_now)
					begin
						sf_mem[base + {4'h0, sf_ptr[s]}] <= conv_data;
						sf_ptr[s] <= sf_ptr[s] + 2'h1;
						last_push[s] <= conv_data;
						ambient_level_value[s] <= new_amb;
						// offsets shrink/grow by half the drift
						off_h[s] <= sat16({2'h0, off_h[s]} - half_drift);
						off_l[s] <= sat16({2'h0, off_l[s]} + half_drift);
					end
				end
				else
				begin
					// touched: follow the user's response peaks
					if (above && max_in)
					begin
						avg_max[s] <= sat16(nxt_max);
						off_h[s] <= sat16(nxt_max - {2'h0, amb_s});
					end
					if (beneath && min_in)
					begin
						avg_min[s] <= sat16(nxt_min);
						off_l[s] <= sat16({2'h0, amb_s} - nxt_min);
					end
				end
			end
			// host writes take effect last
			if (wr_take)
			begin
				if (wa == `ACA_ADDR(`ACA_IDX_SKIP))
					skip_ctrl <= merge16(skip_ctrl, s_axi_wdata, s_axi_wstrb);
				else if (wa == `ACA_ADDR(`ACA_IDX_FFSKIP))
				begin
					if (s_axi_wstrb[0])
						fast_fifo_skip_count <= s_axi_wdata[3:0];
				end
				else if (wa == `ACA_ADDR(`ACA_IDX_UPDATE))
					update_ctrl <= merge16(update_ctrl, s_axi_wdata, s_axi_wstrb);
				else if (wa == `ACA_ADDR(`ACA_IDX_CFG))
					cfg <= merge16(cfg, s_axi_wdata, s_axi_wstrb);
				else if (wa == `ACA_ADDR(`ACA_IDX_SEL))
				begin
					if (s_axi_wstrb[0] && s_axi_wdata[3:0] < `ACA_STAGES)
						sel <= s_axi_wdata[3:0];
				end
				else if (wa == `ACA_ADDR(`ACA_IDX_OFFH))
				begin
					off_h[sel] <= merge16(off_h[sel], s_axi_wdata, s_axi_wstrb);
					rc_valid <= 1'b1;
					rc_stage <= sel;
				end
				else if (wa == `ACA_ADDR(`ACA_IDX_OFFL))
				begin
					off_l[sel] <= merge16(off_l[sel], s_axi_wdata, s_axi_wstrb);
					rc_valid <= 1'b1;
					rc_stage <= sel;
				end
				else if (wa == `ACA_ADDR(`ACA_IDX_SENS))
				begin
					sens[sel] <= merge16(sens[sel], s_axi_wdata, s_axi_wstrb);
					rc_valid <= 1'b1;
					rc_stage <= sel;
				end
			end
		end
	end

	// ****************************************
	// write channel handshake
	// ****************************************
	// address and data are taken together, one cycle after both show
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ACA_RESP_OK;
		end
		else
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (wr_take)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? `ACA_RESP_OK : `ACA_RESP_ERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
				&& !s_axi_bvalid)
			begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ****************************************
	// read channel
	// ****************************************
	reg [31:0] rd_word; // decoded read value
	reg rd_map; // address is mapped
	wire [7:0] ra = s_axi_araddr;

	// window registers show the selected stage
	always @*
	begin
		rd_word = 32'h00000000;
		rd_map = 1'b1;
		if (ra == `ACA_ADDR(`ACA_IDX_SKIP))
			rd_word = {16'h0000, skip_ctrl};
		else if (ra == `ACA_ADDR(`ACA_IDX_FFSKIP))
			rd_word = {28'h0000000, fast_fifo_skip_count};
		else if (ra == `ACA_ADDR(`ACA_IDX_UPDATE))
			rd_word = {16'h0000, update_ctrl};
		else if (ra == `ACA_ADDR(`ACA_IDX_CFG))
			rd_word = {16'h0000, cfg};
		else if (ra == `ACA_ADDR(`ACA_IDX_SEL))
			rd_word = {28'h0000000, sel};
		else if (ra == `ACA_ADDR(`ACA_IDX_OFFH))
			rd_word = {16'h0000, off_h[sel]};
		else if (ra == `ACA_ADDR(`ACA_IDX_OFFL))
			rd_word = {16'h0000, off_l[sel]};
		else if (ra == `ACA_ADDR(`ACA_IDX_SENS))
			rd_word = {16'h0000, sens[sel]};
		else if (ra == `ACA_ADDR(`ACA_IDX_AMB))
			rd_word = {16'h0000, ambient_level_value[sel]};
		else if (ra == `ACA_ADDR(`ACA_IDX_THRH))
			rd_word = {16'h0000, thr_h[sel]};
		else if (ra == `ACA_ADDR(`ACA_IDX_THRL))
			rd_word = {16'h0000, thr_l[sel]};
		else if (ra == `ACA_ADDR(`ACA_IDX_AVGMAX))
			rd_word = {16'h0000, avg_max[sel]};
		else if (ra == `ACA_ADDR(`ACA_IDX_AVGMIN))
			rd_word = {16'h0000, avg_min[sel]};
		else if (ra == `ACA_ADDR(`ACA_IDX_TOUCH))
			rd_word = {4'h0, touch_l, 4'h0, touch_h};
		else
			rd_map = 1'b0;
	end

	// arready pulses one cycle after arvalid; data the edge after
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ACA_RESP_OK;
		end
		else
		begin
			s_axi_arready <= 1'b0;
			if (s_axi_arready && s_axi_arvalid)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_map ? `ACA_RESP_OK : `ACA_RESP_ERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
				s_axi_arready <= 1'b1;
		end
	end

endmodule // aca_top

`default_nettype wire

// *** aca_top_chk.sv ***
/*
 * bus handshake and interrupt checker for the calibration top.
 * assumes one aclk domain and a bind onto every aca_top instance.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aca_map.vh"

// ****************************************
// checker
// ****************************************
module aca_top_chk
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic conv_valid,
	input wire logic int_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// write is taken only with both halves offered, in one cycle
	property p_aw_w_pair;
		s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid;
	endproperty
	a_aw_w_pair: assert property (p_aw_w_pair)
		else $error("write halves not taken together");
	// response follows the accept by one cycle
	property p_b_follows;
		s_axi_awready |=> s_axi_bvalid && !s_axi_awready;
	endproperty
	a_b_follows: assert property (p_b_follows)
		else $error("write response late or ready too long");
	property p_b_holds;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_holds: assert property (p_b_holds)
		else $error("write response dropped early");
	// no write is taken while a write response waits
	property p_no_take_busy;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	a_no_take_busy: assert property (p_no_take_busy)
		else $error("write taken while response pending");
	property p_ar_answer;
		s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |-> ##[1:2] s_axi_arready;
	endproperty
	a_ar_answer: assert property (p_ar_answer)
		else $error("read address not accepted in time");
	property p_r_follows;
		s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_follows: assert property (p_r_follows)
		else $error("read data not one cycle after accept");
	property p_r_holds;
		s_axi_rvalid && !s_axi_rready |=>
			s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_r_holds: assert property (p_r_holds)
		else $error("read data changed before taken");
	// addresses past the touch register are unmapped
	property p_unmapped_rd;
		s_axi_arready && s_axi_araddr >= 8'h4C |=>
			s_axi_rresp == `ACA_RESP_ERR && s_axi_rdata == 32'h00000000;
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd)
		else $error("unmapped read not refused");
	// interrupt level only moves two edges after a result
	property p_int_cause;
		!$stable(int_n) |-> $past(conv_valid, 2);
	endproperty
	a_int_cause: assert property (p_int_cause)
		else $error("interrupt moved without a result");

	c_write: cover property (s_axi_awready ##1 s_axi_bvalid);
	c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == `ACA_RESP_ERR);
	c_int: cover property ($fell(int_n));
endmodule // aca_top_chk

bind aca_top aca_top_chk aca_top_chk_i (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.conv_valid(conv_valid), .int_n(int_n));
`default_nettype wire

// *** aca_conv_src.sv ***
/*
 * converter result source standing in for the capacitance converter.
 * assumes results are taken on every aclk edge with no backpressure.
 */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// converter model
// ****************************************
module aca_conv_src
(
	input wire logic aclk,
	output logic conv_valid,
	output logic [3:0] conv_stage,
	output logic [15:0] conv_data
);
	initial
	begin
		conv_valid = 1'b0;
		conv_stage = 4'h0;
		conv_data = 16'h0000;
	end

	// one result, then idle long enough for flags and thresholds to land
	task automatic send(input logic [3:0] st, input logic [15:0] d);
		@(posedge aclk);
		conv_valid <= 1'b1;
		conv_stage <= st;
		conv_data <= d;
		@(posedge aclk);
		conv_valid <= 1'b0;
		// stale data is inverted so nothing leans on a held value
		conv_data <= ~d;
		repeat (3) @(posedge aclk);
	endtask
endmodule // aca_conv_src
`default_nettype wire

// *** aca_top_tb.sv ***
/*
 * self-checking bench for the ambient calibration top.
 * assumes aca_top, its map header and the converter model alongside.
 */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bench top
// ****************************************
module aca_top_tb;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, conv_valid, int_n;
	logic [3:0] conv_stage;
	logic [15:0] conv_data;
	int n_fail = 0, total_checks = 0, cycles = 0;

	aca_top aca_top_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .conv_valid(conv_valid),
		.conv_stage(conv_stage), .conv_data(conv_data), .int_n(int_n));
	aca_conv_src aca_conv_src_i (.aclk(aclk), .conv_valid(conv_valid),
		.conv_stage(conv_stage), .conv_data(conv_data));

	// 20 mhz clock
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// hang guard, far above the roughly two hundred cycles the run needs
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// each channel is released on its own ready
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (aw && s_axi_awready)
			begin
				s_axi_awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (w && s_axi_wready)
			begin
				s_axi_wvalid <= 1'b0;
				w = 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		logic [1:0] r;
		wr(a, d, r);
		chk({30'h0, r}, {30'h0, e});
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, (a >= 8'h4C) ? 2'h2 : 2'h0});
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		chk({31'h0, int_n}, 32'h00000001);
		rchk(8'h20, 32'h0000000B);
		rchk(8'h0C, 32'h00000000);
		rchk(8'h38, 32'h0000FFFF);
		rchk(8'h80, 32'h00000000);
		wchk(8'h34, 32'h00001234, 2'h2);
		wchk(8'h80, 32'h00001234, 2'h2);
	endtask

	// skips once at setup: full power 2, low power 0
	task automatic t_config();
		wchk(8'h04, 32'h00002000, 2'h0);
		rchk(8'h04, 32'h00002000);
		wchk(8'h0C, 32'h00000010, 2'h0);
		wchk(8'h24, 32'h00000000, 2'h0);
		wchk(8'h28, 32'h00000100, 2'h0);
		wchk(8'h2C, 32'h00000100, 2'h0);
		wchk(8'h30, 32'h0000FF18, 2'h0);
	endtask

	// pos select 8 adds 40/64 of the quarter offset
	task automatic t_seed();
		aca_conv_src_i.send(4'h0, 16'h1000);
		chk({31'h0, int_n}, 32'h00000001);
		rchk(8'h34, 32'h00001000);
		rchk(8'h38, 32'h00001068);
		rchk(8'h3C, 32'h00000FAD);
	endtask

	task automatic t_push();
		aca_conv_src_i.send(4'h0, 16'h1008);
		rchk(8'h34, 32'h00001000);
		aca_conv_src_i.send(4'h0, 16'h1020);
		rchk(8'h34, 32'h00001008);
		rchk(8'h28, 32'h000000FC);
		rchk(8'h2C, 32'h00000104);
		rchk(8'h38, 32'h0000106E);
		rchk(8'h3C, 32'h00000FB4);
	endtask

	// a touch moves the max average, not the ambient
	task automatic t_contact();
		aca_conv_src_i.send(4'h0, 16'h2000);
		chk({31'h0, int_n}, 32'h00000000);
		rchk(8'h48, 32'h00000001);
		rchk(8'h40, 32'h000014C0);
		rchk(8'h28, 32'h000004B8);
		rchk(8'h38, 32'h000011F2);
		rchk(8'h34, 32'h00001008);
		aca_conv_src_i.send(4'h0, 16'h1020);
		chk({31'h0, int_n}, 32'h00000001);
	endtask

	task automatic t_stages();
		aca_conv_src_i.send(4'h1, 16'h3000);
		aca_conv_src_i.send(4'hC, 16'h0000);
		chk({31'h0, int_n}, 32'h00000001);
		wchk(8'h24, 32'h00000001, 2'h0);
		rchk(8'h34, 32'h00003000);
		wchk(8'h24, 32'h00000000, 2'h0);
		rchk(8'h34, 32'h00001008);
		rchk(8'h28, 32'h000004B8);
	endtask

	// one stage per sequence: full power pushes every other sequence,
	// low power with skip 0 pushes every one
	task automatic t_skip();
		wchk(8'h20, 32'h00000000, 2'h0);
		aca_conv_src_i.send(4'h0, 16'h1040);
		aca_conv_src_i.send(4'h0, 16'h1060);
		rchk(8'h34, 32'h00001018);
		wchk(8'h20, 32'h00000100, 2'h0);
		aca_conv_src_i.send(4'h0, 16'h1060);
		aca_conv_src_i.send(4'h0, 16'h1080);
		rchk(8'h34, 32'h00001050);
		rchk(8'h28, 32'h00000494);
	endtask

	// main sequence
	initial
	begin
		aresetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_config();
		t_seed();
		t_push();
		t_contact();
		t_stages();
		t_skip();
		stop_test();
	end
endmodule // aca_top_tb
`default_nettype wire
